// file: rx_pkg.sv
// package: register map, field positions, reset values and timing for the receive data recovery block
// assumes: one module clock hclk at 20 MHz, AHB-Lite register access
//
// Contract
// - the line is sampled on an oversample tick running at sixteen times the baud rate.
// - the phase counter realigns after each start bit and after each data bit change from one to zero.
// - while idle the receiver looks for a zero sample that follows three one samples.
// - that falling edge starts the phase counter on the sixteen ticks of one bit.
// - samples at ticks 3, 5 and 7 verify the start bit; 000, 001, 010, 100 pass, and the last three raise noise.
// - patterns 011, 101, 110 and 111 fail verification, reset the counter and restart the search.
// - each data bit is the majority of ticks 8, 9 and 10, with noise when they differ.
// - ones at ticks 8 to 10 of a verified start bit only raise noise and keep the start bit.
// - the stop bit is the majority of ticks 8, 9 and 10; zero gives framing error, disagreement gives noise.
// - the framing error flag rises in the same cycle as the receive full flag.
// - a break character with no stop bit raises the framing error flag.
// - stop sampling ends 9 bits of 16 ticks plus 10 ticks after the start edge, one bit more for nine data bits.
// - a control bit selects eight or nine data bits, and the ninth bit is kept in its own status position.
// - a finished character moves into the receive data buffer and sets the receive full flag.
package rx_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_DATA   = 8'h08;
    localparam logic [7:0] OFF_BAUD   = 8'h0C;
    localparam logic [7:0] OFF_IRQ_EN = 8'h10;
    localparam logic [7:0] OFF_IRQ_CL = 8'h14;
    // control fields
    localparam int CTRL_EN   = 0;
    localparam int CTRL_NINE = 1;
    // status fields
    localparam int ST_FULL  = 0;
    localparam int ST_FRAME = 1;
    localparam int ST_NOISE = 2;
    localparam int ST_NINTH = 3;
    localparam int ST_BUSY  = 4;
    localparam int NUM_EVT  = 3;
    // reset values
    localparam logic [1:0]  CTRL_RST = 2'h0;
    localparam logic [15:0] BAUD_RST = 16'h0081;
    // timing
    localparam int CLK_HZ     = 20_000_000;
    localparam int TICKS_BIT  = 16;
    localparam int TICK_VER_A = 3;
    localparam int TICK_VER_B = 5;
    localparam int TICK_VER_C = 7;
    localparam int TICK_MAJ_A = 8;
    localparam int TICK_MAJ_B = 9;
    localparam int TICK_MAJ_C = 10;
endpackage : rx_pkg

// file: tick_if.sv
// interface: oversample tick between divider and recovery logic
// assumes: single clock domain
interface tick_if;
    logic        tick;
    logic [15:0] divisor;
    modport gen (input divisor, output tick);
    modport use_ (output divisor, input tick);
endinterface : tick_if

// file: tick_gen.sv
// module: oversample tick divider, one pulse every divisor+1 clocks
// assumes: divisor held steady by software between characters
module tick_gen
    import rx_pkg::*;
(
    // clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    // tick port
    tick_if.gen       tk
);
    logic [15:0] cnt_r;
    logic        tick_r;
    wire         wrap = (cnt_r >= tk.divisor);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r  <= 16'h0000;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= wrap ? 16'h0000 : cnt_r + 16'h0001;
            tick_r <= wrap;
        end
    end

    assign tk.tick = tick_r;
endmodule : tick_gen

// file: rx_recovery.sv
// module: receive data recovery with AHB-Lite registers and one interrupt
// assumes: rxd is a plain level from the remote transmitter, single AHB master
module rx_recovery
    import rx_pkg::*;
(
    // clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // serial line and interrupt
    input  wire logic        rxd,
    output logic             irq
);
    typedef enum logic [1:0] {
        S_HUNT  = 2'b00,
        S_START = 2'b01,
        S_DATA  = 2'b10,
        S_STOP  = 2'b11
    } rx_state_t;

    // synchronizer
    logic sync1_r, sync2_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
        end else begin
            sync1_r <= rxd;
            sync2_r <= sync1_r;
        end
    end

    // tick divider
    tick_if tk ();
    tick_gen u_tick (
        .hclk    (hclk),
        .hresetn (hresetn),
        .tk      (tk)
    );

    // registers
    logic [1:0]         ctrl_r;
    logic [15:0]        baud_r;
    logic [NUM_EVT-1:0] irq_en_r;
    logic [NUM_EVT-1:0] evt_r;
    logic [7:0]         data_r;
    logic               ninth_r;
    assign tk.divisor = baud_r;

    // recovery state
    rx_state_t   st_r;
    logic [3:0]  ph_r;
    logic [2:0]  ones_r;
    logic [2:0]  smp_r;
    logic [3:0]  bit_r;
    logic [8:0]  shf_r;
    logic        prev_bit_r;
    logic        noise_acc_r;
    logic [1:0]  hist_r;

    wire       enabled   = ctrl_r[CTRL_EN];
    wire       nine      = ctrl_r[CTRL_NINE];
    wire       tick      = tk.tick;
    wire [3:0] nbits     = nine ? 4'd9 : 4'd8;
    wire [2:0] ver_smp   = {smp_r[1:0], sync2_r};
    wire [2:0] maj_smp   = {smp_r[1:0], sync2_r};
    wire       maj       = (maj_smp[2] & maj_smp[1]) | (maj_smp[2] & maj_smp[0]) | (maj_smp[1] & maj_smp[0]);
    wire       disagree  = (maj_smp != 3'b000) && (maj_smp != 3'b111);
    wire       ver_ones  = ver_smp[2] + ver_smp[1] + ver_smp[0] >= 2'd2;
    wire       ver_noise = (ver_smp != 3'b000) && !ver_ones;
    wire       at_ver    = tick && (ph_r == 4'(TICK_VER_C));
    wire       at_maj    = tick && (ph_r == 4'(TICK_MAJ_C));
    wire       take_smp  = tick && (ph_r == 4'(TICK_VER_A) || ph_r == 4'(TICK_VER_B) || ph_r == 4'(TICK_MAJ_A)
                                    || ph_r == 4'(TICK_MAJ_B));
    wire       edge_seen = tick && (ones_r == 3'd3) && !sync2_r;
    wire       stop_done = (st_r == S_STOP) && at_maj;
    wire       frame_err = !maj;
    wire       chr_noise = noise_acc_r | disagree;
    // falling edge after a one bit, confirmed by two zero ticks, outside the sample window
    wire       realign   = (st_r == S_DATA) && tick && prev_bit_r && (hist_r == 2'b10) && !sync2_r
                           && (ph_r >= 4'd12 || ph_r <= 4'd5);

    // last two tick samples for edge realignment
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hist_r <= 2'b11;
        end else if (tick) begin
            hist_r <= {hist_r[0], sync2_r};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ones_r <= 3'd0;
        end else if (st_r != S_HUNT || !enabled) begin
            ones_r <= 3'd0;
        end else if (tick) begin
            ones_r <= sync2_r ? ((ones_r == 3'd3) ? 3'd3 : ones_r + 3'd1) : 3'd0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            smp_r <= 3'b000;
        end else if (take_smp) begin
            smp_r <= {smp_r[1:0], sync2_r};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r        <= S_HUNT;
            ph_r        <= 4'd0;
            bit_r       <= 4'd0;
            shf_r       <= 9'h000;
            prev_bit_r  <= 1'b0;
            noise_acc_r <= 1'b0;
        end else if (!enabled) begin
            st_r <= S_HUNT;
            ph_r <= 4'd0;
        end else begin
            if (tick && st_r != S_HUNT) begin
                ph_r <= (ph_r == 4'(TICKS_BIT)) ? 4'd1 : ph_r + 4'd1;
            end
            unique case (st_r)
                S_HUNT: begin
                    if (edge_seen) begin
                        st_r        <= S_START;
                        ph_r        <= 4'd1;
                        noise_acc_r <= 1'b0;
                        bit_r       <= 4'd0;
                    end
                end
                S_START: begin
                    if (at_ver) begin
                        if (ver_ones) begin
                            st_r <= S_HUNT;
                            ph_r <= 4'd0;
                        end else if (ver_noise) begin
                            noise_acc_r <= 1'b1;
                        end
                    end
                    if (at_maj) begin
                        if (maj_smp != 3'b000) begin
                            noise_acc_r <= 1'b1;
                        end
                        st_r       <= S_DATA;
                        prev_bit_r <= 1'b0;
                    end
                end
                S_DATA: begin
                    if (at_maj) begin
                        shf_r      <= {maj, shf_r[8:1]};
                        prev_bit_r <= maj;
                        bit_r      <= bit_r + 4'd1;
                        if (disagree) begin
                            noise_acc_r <= 1'b1;
                        end
                        if (bit_r == nbits - 4'd1) begin
                            st_r <= S_STOP;
                        end
                    end
                    if (realign) begin
                        ph_r <= 4'd2;
                    end
                end
                S_STOP: begin
                    if (at_maj) begin
                        st_r <= S_HUNT;
                        ph_r <= 4'd0;
                    end
                end
            endcase
        end
    end

    // bus address phase capture
    logic       wr_pend_r;
    logic [7:0] addr_r;
    wire        ahb_go  = hsel && hready && htrans[1];
    wire        wr_ctrl = wr_pend_r && addr_r == OFF_CTRL;
    wire        wr_baud = wr_pend_r && addr_r == OFF_BAUD;
    wire        wr_en   = wr_pend_r && addr_r == OFF_IRQ_EN;
    wire        wr_clr  = wr_pend_r && addr_r == OFF_IRQ_CL;
    wire        rd_data = ahb_go && !hwrite && haddr == OFF_DATA;

    // events: full, framing, noise
    wire [NUM_EVT-1:0] evt_set = stop_done ? {chr_noise, frame_err, 1'b1} : {NUM_EVT{1'b0}};
    wire [NUM_EVT-1:0] evt_clr = (wr_clr ? hwdata[NUM_EVT-1:0] : {NUM_EVT{1'b0}})
                                 | (rd_data ? 3'b001 : 3'b000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_r <= {NUM_EVT{1'b0}};
        end else begin
            evt_r <= evt_set | (evt_r & ~evt_clr);
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_r  <= 8'h00;
            ninth_r <= 1'b0;
        end else if (stop_done) begin
            data_r  <= nine ? shf_r[7:0] : shf_r[8:1];
            ninth_r <= nine ? shf_r[8] : shf_r[8];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
            ctrl_r    <= CTRL_RST;
            baud_r    <= BAUD_RST;
            irq_en_r  <= {NUM_EVT{1'b0}};
        end else begin
            wr_pend_r <= ahb_go && hwrite;
            if (ahb_go) begin
                addr_r <= haddr;
            end
            if (wr_ctrl) begin
                ctrl_r <= hwdata[1:0];
            end
            if (wr_baud) begin
                baud_r <= hwdata[15:0];
            end
            if (wr_en) begin
                irq_en_r <= hwdata[NUM_EVT-1:0];
            end
        end
    end

    // read mux, registered in the address phase
    wire [31:0] status_w = {27'h0, st_r != S_HUNT, ninth_r, evt_r};
    wire [31:0] rd_mux   = (haddr == OFF_CTRL)   ? {30'h0, ctrl_r} :
                           (haddr == OFF_STATUS) ? status_w :
                           (haddr == OFF_DATA)   ? {24'h0, data_r} :
                           (haddr == OFF_BAUD)   ? {16'h0, baud_r} :
                           (haddr == OFF_IRQ_EN) ? {29'h0, irq_en_r} : 32'h0000_0000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            irq       <= 1'b0;
        end else begin
            if (ahb_go && !hwrite) begin
                hrdata <= rd_mux;
            end
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            irq       <= |(evt_r & irq_en_r);
        end
    end
endmodule : rx_recovery

// file: rx_recovery_chk.sv
// checker: bus and interrupt relations at the receive block ports
// assumes: bound to rx_recovery, one clock
module rx_recovery_chk
    import rx_pkg::*;
(
    // clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // bus
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // line and interrupt
    input wire logic        rxd,
    input wire logic        irq
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire  ap    = hsel && hready && htrans[1];
    wire  rd_ap = ap && !hwrite;
    logic en_ap_r;
    logic en_seen_r;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_ap_r   <= 1'b0;
            en_seen_r <= 1'b0;
        end else begin
            en_ap_r   <= ap && hwrite && haddr == OFF_IRQ_EN;
            en_seen_r <= en_seen_r || (en_ap_r && hwdata[2:0] != 3'h0);
        end
    end
    a_ready_high: assert property (hreadyout) else $error("hreadyout low");
    a_resp_okay: assert property (!hresp) else $error("hresp not okay");
    a_unmapped_zero: assert property (rd_ap && haddr == 8'h18 |=> hrdata == 32'h0) else $error("unmapped read");
    a_status_upper: assert property (rd_ap && haddr == OFF_STATUS |=> hrdata[31:5] == 27'h0)
        else $error("status high bits");
    a_rdata_holds: assert property (!$past(rd_ap) |-> $stable(hrdata)) else $error("read data moved");
    a_irq_needs_en: assert property (irq |-> en_seen_r) else $error("irq without enable");
    a_irq_cleared: assert property (ap && hwrite && haddr == OFF_IRQ_CL ##1 hwdata[2:0] == 3'h7 |=> ##2 !irq)
        else $error("irq after clear");
    a_reset_quiet: assert property ($rose(hresetn) |-> !irq && hrdata == 32'h0) else $error("reset outputs");
    c_irq_rise: cover property ($rose(irq));
    c_clear: cover property (ap && hwrite && haddr == OFF_IRQ_CL);
    c_unmapped: cover property (rd_ap && haddr == 8'h18);
endmodule : rx_recovery_chk

// file: rx_line_src.sv
// model: remote serial transmitter, one frame per go, optional inverted span
// assumes: frame given LSB first with start and stop bits in place
module rx_line_src (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // frame request
    input  wire logic        go,
    input  wire logic [11:0] frame,
    input  wire logic [3:0]  nbits,
    input  wire logic [7:0]  bit_clks,
    input  wire logic [3:0]  g_bit,
    input  wire logic [7:0]  g_off,
    input  wire logic [7:0]  g_len,
    // line
    output logic             busy,
    output logic             line
);
    logic [7:0] cnt_r;
    logic [3:0] idx_r;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy  <= 1'b0;
            cnt_r <= 8'h00;
            idx_r <= 4'h0;
        end else if (go && !busy) begin
            busy  <= 1'b1;
            cnt_r <= 8'h00;
            idx_r <= 4'h0;
        end else if (busy && cnt_r == bit_clks - 8'h01) begin
            cnt_r <= 8'h00;
            busy  <= idx_r != nbits - 4'h1;
            idx_r <= idx_r + 4'h1;
        end else if (busy) begin
            cnt_r <= cnt_r + 8'h01;
        end
    end
    wire glitch = busy && idx_r == g_bit && cnt_r >= g_off && cnt_r < g_off + g_len;
    assign line = busy ? frame[idx_r] ^ glitch : 1'b1;
endmodule : rx_line_src

// file: uart_rx_data_recovery_bench.sv
// bench: frames of every kind through the receive block, results over the bus
// assumes: design package compiled first, divisor 1 gives a tick every 2 clocks
module uart_rx_data_recovery_bench;
    import rx_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        hclk, hresetn, hsel, hwrite, go;
    logic [7:0]  haddr, bit_clks, g_off, g_len;
    logic [1:0]  htrans;
    logic [31:0] hwdata, rd, seed, e;
    logic [11:0] frame;
    logic [3:0]  nbits, g_bit;
    logic [8:0]  d;
    wire  [31:0] hrdata;
    wire         hreadyout, hresp, irq, rxd, busy;
    int          err_total, n_tests, i;
    int          exp_q[$];
    // nine, kind (0 data, 1 break, 2 false start), bit clocks, glitch bit, offset, length
    int tab[10][6] = '{'{0,0,32,0,0,0}, '{1,0,32,0,0,0}, '{0,0,32,0,7,4}, '{0,0,32,3,20,2},
        '{0,0,32,0,20,2}, '{0,1,32,0,0,0}, '{0,2,32,0,0,8}, '{1,0,33,0,0,0}, '{0,0,31,0,0,0}, '{0,0,32,9,20,2}};
    rx_recovery dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp, .rxd, .irq);
    rx_line_src src_u (.clk(hclk), .rstn(hresetn), .go, .frame, .nbits, .bit_clks, .g_bit, .g_off, .g_len,
        .busy, .line(rxd));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1; haddr <= a; htrans <= 2'h2; hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    task automatic send(input int nine, input int kind);
        frame <= kind == 1 ? 12'h000 : kind == 2 ? 12'hFFF : nine ? {2'b11, d, 1'b0} : {3'b111, d[7:0], 1'b0};
        nbits <= nine ? 4'hB : 4'hA;
        exp_q.push_back(kind == 2 ? 0 : {kind == 1 ? 1'b0 : nine ? d[8] : d[7], g_len != 0, kind == 1, 1'b1});
        exp_q.push_back(kind == 1 ? 0 : d[7:0]);
        go <= 1'b1;
        @(posedge hclk);
        go <= 1'b0;
        do @(posedge hclk); while (busy !== 1'b0);
        repeat (4) @(posedge hclk);
    endtask : send
    task automatic report_and_stop();
        $display("errors %0d checks %0d", err_total, n_tests);
        if (err_total == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    initial begin
        repeat (30000) @(posedge hclk);
        err_total++;
        report_and_stop();
    end
    initial begin
        {hresetn, hsel, hwrite, go, haddr, htrans, hwdata, g_bit, g_off, g_len} = '0;
        frame = 12'hFFF; nbits = 4'hA; bit_clks = 8'h20; d = 9'h000; seed = 32'h0001_78D3;
        err_total = 0; n_tests = 0;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, OFF_CTRL, 32'h0); check("ctrl reset", rd, 32'h0);
        bus(1'b0, OFF_BAUD, 32'h0); check("baud reset", rd, {16'h0000, BAUD_RST});
        bus(1'b0, 8'h18, 32'h0); check("unmapped", rd, 32'h0);
        bus(1'b1, OFF_BAUD, 32'h1); bus(1'b1, OFF_CTRL, 32'h1);
        for (i = 0; i < 10; i++) begin
            bus(1'b1, OFF_CTRL, {30'h0, tab[i][0] != 0, 1'b1});
            seed = lfsr(seed);
            d <= tab[i][1] == 1 ? 9'h000 : seed[8:0];
            bit_clks <= tab[i][2]; g_bit <= tab[i][3]; g_off <= tab[i][4]; g_len <= tab[i][5];
            @(posedge hclk);
            send(tab[i][0], tab[i][1]);
            e = exp_q.pop_front();
            if (i == 0) begin
                check("irq masked", irq, 32'h0);
                bus(1'b1, OFF_IRQ_EN, 32'h7);
                repeat (2) @(posedge hclk);
            end
            check("irq", irq, {31'h0, e[0]});
            bus(1'b0, OFF_STATUS, 32'h0); check("status", rd, e);
            e = exp_q.pop_front();
            if (tab[i][1] != 2) begin
                bus(1'b0, OFF_DATA, 32'h0); check("data", rd, e);
            end
            bus(1'b1, OFF_IRQ_CL, 32'h7);
            repeat (2) @(posedge hclk);
            check("irq clear", irq, 32'h0);
        end
        report_and_stop();
    end
endmodule : uart_rx_data_recovery_bench
bind rx_recovery rx_recovery_chk chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .rxd, .irq);
